// >>> src/upoc_top.sv
// User pattern output control: APB registers, pattern load and serial stream
`timescale 1ns/100ps
// How it works
// - Load format is 1 or 8 bits per byte; reset gives 1 bit.
// - One format governs whole and incremental writes and their readbacks.
// - In 1-bit format a byte holds one bit at bit 0, rest zero.
// - In 8-bit format unused trailing bits of the last byte read zero.
// - Incremental read returns exactly count bits from start, current format.
// - Half-change source external (aux input) or internal; reset is external.
// - Alternate mode, external: aux level picks half A or B; default mode.
// - Alternate mode, internal: half-select picks A or B; resets to A.
// - One-shot, external: each aux rising edge starts one burst of B.
// - One-shot, internal: insert-B command starts a burst; no readback.
// - Burst repeats B the fewest times giving a bit total divisible by 256.
// - Single-error command flips one bit and turns error insertion off, fixed and external.
// - Error insertion enable switches continuous errors; off after reset.
// - External error source: each pulse on error input adds one error.
// - Fixed source adds errors at the programmed rate; default source.
// - Rate runs 1E-3 to 1E-9 in decade steps only.
// - Transfer bit positions count from zero at the first pattern bit.
// - In 8-bit format byte MSB is the first pattern bit.
// - Pattern is two halves A and B; half control picks the output half.
module upoc_top
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External controls
   input wire logic auxIn,
   input wire logic extErrIn,
   // Serial stream to the device under test
   output logic serialOut,
   output logic halfOut,
   output logic burstActive
);
   typedef enum logic [2:0] {ST_IDLE, ST_WBIT, ST_RWAIT, ST_RDATA, ST_DONE} upoc_xfer_e;

   localparam int PW = upoc_pkg::POS_W;

   // Period in bits between fixed-rate errors for a decade code
   function automatic logic [29:0] decadePeriod(input logic [3:0] rate);
      logic [29:0] p;
      p = 30'h0000_03E8;
      case (rate)
         4'h3: p = 30'h0000_03E8;
         4'h4: p = 30'h0000_2710;
         4'h5: p = 30'h0001_86A0;
         4'h6: p = 30'h000F_4240;
         4'h7: p = 30'h0098_9680;
         4'h8: p = 30'h05F5_E100;
         4'h9: p = 30'h3B9A_CA00;
         default: p = 30'h0000_03E8;
      endcase
      return p;
   endfunction

   // Fewest half repeats whose bit total divides by 256
   function automatic logic [8:0] burstReps(input logic [PW-1:0] len);
      logic [8:0] reps;
      logic found;
      reps = 9'(upoc_pkg::BURST_MOD);
      found = 1'b0;
      for (int i = 0; i < upoc_pkg::BYTE_BITS; i++)
      begin
         if (!found && !len[i])
            reps = reps >> 1;
         else
            found = 1'b1;
      end
      return reps;
   endfunction

   function automatic logic rateValid(input logic [3:0] rate);
      return (rate >= upoc_pkg::RATE_MIN) && (rate <= upoc_pkg::RATE_MAX);
   endfunction

   // Control state
   logic fmt8;
   logic hsrcInt;
   logic single_burst_mode;
   logic hselB;
   logic errEn;
   logic errExt;
   logic [3:0] rate;
   logic [PW-1:0] halfLen;

   // Transfer state
   upoc_xfer_e state;
   logic [PW-1:0] ptr;
   logic [PW-1:0] left;
   logic xferHalf;
   logic [7:0] shifter;
   logic [3:0] nb;

   // Stream state
   logic [PW-1:0] outPos;
   logic outHalf;
   logic [8:0] burstLeft;
   logic burstReq;
   logic auxPrev;
   logic errPrev;
   logic [29:0] rateCnt;
   logic singleErr;
   logic insertCmd;

   // Memory wires
   logic qA;
   logic qB;
   logic memWe;
   logic nextHalf;
   logic [31:0] readMux;

   // Bus decode; a request is served once, in the idle state
   logic accCycle;
   logic wrCtrl;
   logic wrCmd;
   logic wrLen;
   logic hit;
   assign accCycle = psel && penable && !pready && (state == ST_IDLE);
   assign wrCtrl = accCycle && pwrite && (paddr == upoc_pkg::OFF_CTRL);
   assign wrCmd = accCycle && pwrite && (paddr == upoc_pkg::OFF_CMD);
   assign wrLen = accCycle && pwrite && (paddr == upoc_pkg::OFF_LEN);
   assign hit = (paddr == upoc_pkg::OFF_CTRL) || (paddr == upoc_pkg::OFF_CMD)
      || (paddr == upoc_pkg::OFF_LEN) || (paddr == upoc_pkg::OFF_XSTART)
      || (paddr == upoc_pkg::OFF_XCOUNT) || (paddr == upoc_pkg::OFF_DATA)
      || (paddr == upoc_pkg::OFF_STATUS);

   // Event edges on the external inputs
   logic auxRise;
   logic extErrRise;
   logic fixedTick;
   logic errNow;
   assign auxRise = auxIn && !auxPrev;
   assign extErrRise = extErrIn && !errPrev;
   assign fixedTick = (rateCnt == 30'h0000_0000);
   assign errNow = singleErr || (errEn && !errExt && fixedTick)
      || (errEn && errExt && extErrRise);

   // Configuration register
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         fmt8 <= 1'b0;
         hsrcInt <= 1'b0;
         single_burst_mode <= 1'b0;
         hselB <= 1'b0;
         errEn <= 1'b0;
         errExt <= 1'b0;
         rate <= upoc_pkg::RST_RATE;
      end
      else if (wrCtrl)
      begin
         fmt8 <= pwdata[upoc_pkg::CTRL_FMT8];
         hsrcInt <= pwdata[upoc_pkg::CTRL_HSRC_INT];
         single_burst_mode <= pwdata[upoc_pkg::CTRL_SINGLE_BURST_MODE];
         hselB <= pwdata[upoc_pkg::CTRL_HSEL_B];
         errEn <= pwdata[upoc_pkg::CTRL_ERR_EN];
         errExt <= pwdata[upoc_pkg::CTRL_ERR_EXT];
         // Out-of-range decades are dropped, old rate kept
         if (rateValid(pwdata[upoc_pkg::CTRL_RATE_HI:upoc_pkg::CTRL_RATE_LO]))
            rate <= pwdata[upoc_pkg::CTRL_RATE_HI:upoc_pkg::CTRL_RATE_LO];
      end
      else if (wrCmd && pwdata[upoc_pkg::CMD_SINGLE_ERR])
      begin
         errEn <= 1'b0;
      end
   end

   // Command pulses; insert-B counts only in internal one-shot use
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         singleErr <= 1'b0;
         insertCmd <= 1'b0;
      end
      else
      begin
         singleErr <= wrCmd && pwdata[upoc_pkg::CMD_SINGLE_ERR];
         insertCmd <= wrCmd && pwdata[upoc_pkg::CMD_INSERT_B] && single_burst_mode && hsrcInt;
      end
   end

   // Half length; zero would stall the stream so it is refused
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         halfLen <= upoc_pkg::RST_LEN;
      else if (wrLen && (pwdata[PW-1:0] != '0) && (pwdata[PW-1:0] <= upoc_pkg::HALF_BITS))
         halfLen <= pwdata[PW-1:0];
   end

   // Read data selection for plain registers
   always_comb
   begin
      readMux = upoc_pkg::ZERO_WORD;
      case (paddr)
         upoc_pkg::OFF_CTRL:
         begin
            readMux[upoc_pkg::CTRL_FMT8] = fmt8;
            readMux[upoc_pkg::CTRL_HSRC_INT] = hsrcInt;
            readMux[upoc_pkg::CTRL_SINGLE_BURST_MODE] = single_burst_mode;
            readMux[upoc_pkg::CTRL_HSEL_B] = hselB;
            readMux[upoc_pkg::CTRL_ERR_EN] = errEn;
            readMux[upoc_pkg::CTRL_ERR_EXT] = errExt;
            readMux[upoc_pkg::CTRL_RATE_HI:upoc_pkg::CTRL_RATE_LO] = rate;
         end
         upoc_pkg::OFF_LEN: readMux[PW-1:0] = halfLen;
         upoc_pkg::OFF_XSTART:
         begin
            readMux[PW-1:0] = ptr;
            readMux[upoc_pkg::XSTART_HALF] = xferHalf;
         end
         upoc_pkg::OFF_XCOUNT: readMux[PW-1:0] = left;
         upoc_pkg::OFF_STATUS:
         begin
            readMux[0] = outHalf;
            readMux[1] = burstActive;
            readMux[2] = burstReq;
            readMux[24:16] = burstLeft;
         end
         default: readMux = upoc_pkg::ZERO_WORD;
      endcase
   end

   // Host bit writes go to the selected half at the running pointer
   logic ptrInRange;
   assign ptrInRange = ptr < halfLen;
   assign memWe = (state == ST_WBIT) && (nb != 4'h0) && (left != '0) && ptrInRange;

   // Transfer engine and bus answers
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= ST_IDLE;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= upoc_pkg::ZERO_WORD;
         ptr <= '0;
         left <= '0;
         xferHalf <= 1'b0;
         shifter <= 8'h00;
         nb <= 4'h0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (accCycle && (paddr == upoc_pkg::OFF_DATA))
               begin
                  if (pwrite && !fmt8 && (pwdata[7:1] != 7'h00))
                  begin
                     // Only 0 or 1 is legal per byte in 1-bit format
                     pready <= 1'b1;
                     pslverr <= 1'b1;
                     state <= ST_DONE;
                  end
                  else
                  begin
                     shifter <= fmt8 ? pwdata[7:0] : {pwdata[0], 7'h00};
                     nb <= fmt8 ? 4'h8 : 4'h1;
                     state <= pwrite ? ST_WBIT : ST_RWAIT;
                  end
               end
               else if (accCycle)
               begin
                  pready <= 1'b1;
                  pslverr <= !hit;
                  prdata <= pwrite ? upoc_pkg::ZERO_WORD : readMux;
                  if (pwrite && (paddr == upoc_pkg::OFF_XSTART))
                  begin
                     ptr <= pwdata[PW-1:0];
                     xferHalf <= pwdata[upoc_pkg::XSTART_HALF];
                  end
                  if (pwrite && (paddr == upoc_pkg::OFF_XCOUNT))
                     left <= pwdata[PW-1:0];
                  state <= ST_DONE;
               end
            end
            ST_WBIT:
            begin
               if ((nb != 4'h0) && (left != '0))
               begin
                  // Bits past the half length are consumed but dropped
                  ptr <= ptr + 1'b1;
                  left <= left - 1'b1;
                  shifter <= {shifter[6:0], 1'b0};
                  nb <= nb - 4'h1;
               end
               else
               begin
                  pready <= 1'b1;
                  prdata <= upoc_pkg::ZERO_WORD;
                  state <= ST_DONE;
               end
            end
            ST_RWAIT:
            begin
               state <= ST_RDATA; // Memory latches the bit at ptr
            end
            ST_RDATA:
            begin
               if ((nb != 4'h0) && (left != '0))
               begin
                  shifter <= {shifter[6:0], qB && ptrInRange};
                  ptr <= ptr + 1'b1;
                  left <= left - 1'b1;
                  nb <= nb - 4'h1;
                  state <= ST_RWAIT;
               end
               else
               begin
                  // Short final byte is left aligned, tail zero
                  pready <= 1'b1;
                  prdata <= {24'h00_0000, 8'(shifter << nb)};
                  state <= ST_DONE;
               end
            end
            ST_DONE:
            begin
               pready <= 1'b0;
               pslverr <= 1'b0;
               state <= ST_IDLE;
            end
            default:
            begin
               pready <= 1'b0;
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Pattern store, one half in each upper address half
   upoc_pat_mem upoc_pat_mem_i
   (
      .mclk(mclk),
      .we(memWe),
      .waddr({xferHalf, ptr[PW-2:0]}),
      .wbit(shifter[7]),
      .raddrA({outHalf, outPos[PW-2:0]}),
      .qA(qA),
      .raddrB({xferHalf, ptr[PW-2:0]}),
      .qB(qB)
   );

   // Half chosen for the next pass; bursts take priority in one-shot
   always_comb
   begin
      if (!single_burst_mode)
         nextHalf = hsrcInt ? hselB : auxIn;
      else
         nextHalf = (burstLeft != 9'h000) || burstReq;
   end

   // Input edge history
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         auxPrev <= 1'b0;
         errPrev <= 1'b0;
      end
      else
      begin
         auxPrev <= auxIn;
         errPrev <= extErrIn;
      end
   end

   // Burst request is sticky; a new trigger beats the clear
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         burstReq <= 1'b0;
      else if (!single_burst_mode)
         burstReq <= 1'b0;
      else if ((!hsrcInt && auxRise) || insertCmd)
         burstReq <= 1'b1;
      else if ((outPos >= halfLen - 1'b1) && (burstLeft == 9'h000))
         burstReq <= 1'b0;
   end

   // Stream position; half swaps only on the last bit of a half
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         outPos <= '0;
         outHalf <= 1'b0;
         burstLeft <= 9'h000;
         burstActive <= 1'b0;
      end
      else if (outPos >= halfLen - 1'b1)
      begin
         outPos <= '0;
         outHalf <= nextHalf;
         burstActive <= single_burst_mode && nextHalf;
         if (!single_burst_mode)
            burstLeft <= 9'h000;
         else if (burstLeft != 9'h000)
            burstLeft <= burstLeft - 9'h001;
         else if (burstReq)
            burstLeft <= burstReps(halfLen) - 9'h001;
      end
      else
      begin
         outPos <= outPos + 1'b1;
      end
   end

   // Fixed-rate spacing counter, reloaded each tick or when disabled
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         rateCnt <= 30'h0000_0001;
      else if (!errEn || errExt || fixedTick)
         rateCnt <= decadePeriod(rate) - 30'h0000_0001;
      else
         rateCnt <= rateCnt - 30'h0000_0001;
   end

   // Serial output; coincident error events still flip a single bit
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         serialOut <= 1'b0;
         halfOut <= 1'b0;
      end
      else
      begin
         serialOut <= qA ^ errNow;
         halfOut <= outHalf;
      end
   end
endmodule

// >>> shared/upoc_pkg.sv
// Constants shared by the user pattern output control block
package upoc_pkg;
   // Register byte offsets on the APB bus
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CMD = 8'h04;
   localparam logic [7:0] OFF_LEN = 8'h08;
   localparam logic [7:0] OFF_XSTART = 8'h0C;
   localparam logic [7:0] OFF_XCOUNT = 8'h10;
   localparam logic [7:0] OFF_DATA = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;

   // Control register field positions
   localparam int CTRL_FMT8 = 0;
   localparam int CTRL_HSRC_INT = 1;
   localparam int CTRL_SINGLE_BURST_MODE = 2;
   localparam int CTRL_HSEL_B = 3;
   localparam int CTRL_ERR_EN = 4;
   localparam int CTRL_ERR_EXT = 5;
   localparam int CTRL_RATE_LO = 8;
   localparam int CTRL_RATE_HI = 11;

   // Command register field positions
   localparam int CMD_INSERT_B = 0;
   localparam int CMD_SINGLE_ERR = 1;

   // Transfer start register: half select bit
   localparam int XSTART_HALF = 16;

   // Pattern geometry
   localparam int POS_W = 13;
   localparam logic [POS_W-1:0] HALF_BITS = 13'h1000;
   localparam int MEM_AW = POS_W;
   localparam int BYTE_BITS = 8;
   localparam int BURST_MOD = 256;
   localparam int REPS_W = 9;

   // Error rate decades, 1E-3 down to 1E-9
   localparam logic [3:0] RATE_MIN = 4'h3;
   localparam logic [3:0] RATE_MAX = 4'h9;

   // Values after reset
   localparam logic [3:0] RST_RATE = 4'h3;
   localparam logic [POS_W-1:0] RST_LEN = 13'h0001;

   // Register answers
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

// >>> src/upoc_pat_mem.sv
// Bit-wide pattern store with one write port and two registered read ports
`timescale 1ns/100ps
module upoc_pat_mem
(
   // Clock
   input wire logic mclk,
   // Write port
   input wire logic we,
   input wire logic [upoc_pkg::MEM_AW-1:0] waddr,
   input wire logic wbit,
   // Read port for the serial stream
   input wire logic [upoc_pkg::MEM_AW-1:0] raddrA,
   output logic qA,
   // Read port for host readback
   input wire logic [upoc_pkg::MEM_AW-1:0] raddrB,
   output logic qB
);
   logic store [0:(1 << upoc_pkg::MEM_AW)-1];

   // No reset on the array; contents are whatever software loads
   always_ff @(posedge mclk)
   begin
      if (we)
      begin
         store[waddr] <= wbit;
      end
   end

   // Registered reads, one cycle after the address
   always_ff @(posedge mclk)
   begin
      qA <= store[raddrA];
      qB <= store[raddrB];
   end
endmodule

// >>> dv/upoc_top_checker.sv
// Concurrent checks on the ports of the user pattern output control top
`timescale 1ns/100ps
module upoc_top_checker
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // External controls
   input wire logic auxIn,
   input wire logic extErrIn,
   // Serial stream
   input wire logic serialOut,
   input wire logic halfOut,
   input wire logic burstActive
);
   logic [5:0] ctrlSh;
   logic lenOne;
   logic [2:0] calmCnt;
   logic [20:0] runLen;
   logic cfgWr;
   logic altInt;
   logic altExt;
   logic shotInt;
   logic shotExt;

   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);

   // Mode decode from the shadow copy
   assign cfgWr = pready && pwrite && !pslverr &&
      (paddr == upoc_pkg::OFF_CTRL || paddr == upoc_pkg::OFF_LEN);
   assign altInt = ctrlSh[2:1] == 2'b01;
   assign altExt = ctrlSh[2:1] == 2'b00;
   assign shotInt = ctrlSh[2:1] == 2'b11;
   assign shotExt = ctrlSh[2:1] == 2'b10;

   // Shadow lags the design by one edge, so it never runs ahead of it
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         ctrlSh <= 6'h00;
      else if (cfgWr && paddr == upoc_pkg::OFF_CTRL)
         ctrlSh <= pwdata[5:0];
   end

   // Half length of one bit makes every bit a half boundary
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         lenOne <= 1'b1;
      else if (cfgWr && paddr == upoc_pkg::OFF_LEN && pwdata != 32'h0 && pwdata <= 32'h1000)
         lenOne <= pwdata[12:0] == 13'h0001;
   end

   // Cycles since the last setting change, saturating
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         calmCnt <= 3'h0;
      else if (cfgWr)
         calmCnt <= 3'h0;
      else if (calmCnt != 3'h7)
         calmCnt <= calmCnt + 3'h1;
   end

   // Length of the current burst run
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         runLen <= 21'h0;
      else if (burstActive)
         runLen <= runLen + 21'h1;
      else
         runLen <= 21'h0;
   end

   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
      else $error("pready without an access cycle");
   a_slverr_pair: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_cfg_answer: assert property (psel && $rose(penable) &&
      (paddr == upoc_pkg::OFF_CTRL || paddr == upoc_pkg::OFF_LEN) |=> pready)
      else $error("plain register answer late");
   a_unmapped_zero: assert property (pready && !pwrite && paddr >= 8'h1C |->
      pslverr && prdata == 32'h0)
      else $error("unmapped read not refused with zero");
   a_half_internal: assert property (calmCnt == 3'h7 && lenOne && altInt |->
      halfOut == ctrlSh[3])
      else $error("internal half select not followed");
   a_half_aux: assert property ($rose(auxIn) && !psel && lenOne && altExt &&
      calmCnt == 3'h7 |-> ##[1:3] halfOut)
      else $error("aux level did not select half B");
   a_burst_cmd: assert property (pready && pwrite && paddr == upoc_pkg::OFF_CMD &&
      pwdata[upoc_pkg::CMD_INSERT_B] && shotInt && lenOne |-> ##[0:6] burstActive)
      else $error("insert command started no burst");
   a_burst_aux: assert property ($rose(auxIn) && shotExt && lenOne &&
      calmCnt == 3'h7 |-> ##[1:6] burstActive)
      else $error("aux edge started no burst");
   a_burst_len: assert property ($fell(burstActive) |->
      runLen[7:0] == 8'h00 && runLen != 21'h0)
      else $error("burst length not a multiple of 256");
endmodule

// >>> dv/upoc_dut_rx.sv
// Error-counting receiver standing in for the device under test
`timescale 1ns/100ps
module upoc_dut_rx
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Stream and the bit it ought to carry
   input wire logic serialIn,
   input wire logic refBit,
   input wire logic clr,
   // Bits that differed since the last clear
   output logic [15:0] missCount
);
   // Unknown bits count as misses so an undriven stream is seen
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         missCount <= 16'h0000;
      else if (clr)
         missCount <= 16'h0000;
      else if (serialIn !== refBit)
         missCount <= missCount + 16'h0001;
   end
endmodule

// >>> dv/upoc_top_test.sv
// Self-checking bench for the user pattern output control top
`timescale 1ns/100ps
module upoc_top_test;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic auxIn = 1'b0;
   logic extErrIn = 1'b0;
   logic refBit = 1'b1;
   logic clr = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic serialOut;
   logic halfOut;
   logic burstActive;
   logic [15:0] missCount;
   logic [31:0] rdv;
   logic errv;
   logic [8:0] pat = 9'h137;
   int n_fail = 0;
   int comparisons = 0;
   int cyc = 0;

   upoc_top upoc_top_i (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .auxIn(auxIn), .extErrIn(extErrIn), .serialOut(serialOut),
      .halfOut(halfOut), .burstActive(burstActive));
   upoc_dut_rx upoc_dut_rx_i (.mclk(mclk), .rstn(rstn), .serialIn(serialOut),
      .refBit(refBit), .clr(clr), .missCount(missCount));

   // 50 MHz clock
   always #10 mclk = ~mclk;

   // Hang guard, well above the expected run length
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         conclude();
      end
   end

   task conclude();
      if (n_fail == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      xfer(1'b0, a, 32'h0);
      chk(nm, rdv, e);
   endtask

   // Settle, then clear the receiver's miss count
   task arm();
      repeat (8) @(posedge mclk);
      clr <= 1'b1;
      @(posedge mclk);
      clr <= 1'b0;
   endtask

   task look(input int n, input logic [15:0] e, input string nm);
      repeat (n) @(posedge mclk);
      #1;
      chk(nm, {16'h0, missCount}, {16'h0, e});
   endtask

   initial
   begin
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      rd(upoc_pkg::OFF_CTRL, 32'h300, "ctrlReset");
      rd(upoc_pkg::OFF_LEN, 32'h1, "lenReset");
      rd(upoc_pkg::OFF_CMD, 32'h0, "cmdRead");
      // Zero and oversize lengths are refused, old length kept
      wr(upoc_pkg::OFF_LEN, 32'h0);
      wr(upoc_pkg::OFF_LEN, 32'h1001);
      rd(upoc_pkg::OFF_LEN, 32'h1, "lenKeep");
      xfer(1'b0, 8'h40, 32'h0);
      chk("unmapErr", {31'h0, errv}, 32'h1);
      for (int r = 2; r <= 10; r++)
      begin
         wr(upoc_pkg::OFF_CTRL, 32'h0 | (r << 8));
         rd(upoc_pkg::OFF_CTRL, (r < 3 ? 3 : (r > 9 ? 9 : r)) << 8, "rate");
      end
      // Packed format: clear, partial write, then reads
      wr(upoc_pkg::OFF_LEN, 32'h10);
      wr(upoc_pkg::OFF_CTRL, 32'h301);
      wr(upoc_pkg::OFF_XSTART, 32'h0);
      wr(upoc_pkg::OFF_XCOUNT, 32'h10);
      wr(upoc_pkg::OFF_DATA, 32'h0);
      wr(upoc_pkg::OFF_DATA, 32'h0);
      wr(upoc_pkg::OFF_XSTART, 32'h3);
      wr(upoc_pkg::OFF_XCOUNT, 32'h9);
      wr(upoc_pkg::OFF_DATA, 32'h9B);
      wr(upoc_pkg::OFF_DATA, 32'hFF);
      wr(upoc_pkg::OFF_XSTART, 32'h0);
      wr(upoc_pkg::OFF_XCOUNT, 32'h10);
      rd(upoc_pkg::OFF_DATA, 32'h13, "full0");
      rd(upoc_pkg::OFF_DATA, 32'h70, "full1");
      wr(upoc_pkg::OFF_XSTART, 32'h3);
      wr(upoc_pkg::OFF_XCOUNT, 32'h9);
      rd(upoc_pkg::OFF_DATA, 32'h9B, "inc0");
      rd(upoc_pkg::OFF_DATA, 32'h80, "inc1");
      // Pointer stands just past the run, nothing left to move
      rd(upoc_pkg::OFF_XSTART, 32'hC, "ptrEnd");
      rd(upoc_pkg::OFF_XCOUNT, 32'h0, "cntEnd");
      // Same bits in one-bit format
      wr(upoc_pkg::OFF_CTRL, 32'h300);
      wr(upoc_pkg::OFF_XSTART, 32'h3);
      wr(upoc_pkg::OFF_XCOUNT, 32'h9);
      for (int i = 0; i < 9; i++)
         rd(upoc_pkg::OFF_DATA, {31'h0, pat[8-i]}, "bit");
      // Stream setup: half A is 1, half B is 0
      wr(upoc_pkg::OFF_LEN, 32'h1);
      wr(upoc_pkg::OFF_XSTART, 32'h0);
      wr(upoc_pkg::OFF_XCOUNT, 32'h1);
      xfer(1'b1, upoc_pkg::OFF_DATA, 32'h2);
      chk("badByte", {31'h0, errv}, 32'h1);
      wr(upoc_pkg::OFF_DATA, 32'h1);
      wr(upoc_pkg::OFF_XSTART, 32'h1_0000);
      wr(upoc_pkg::OFF_XCOUNT, 32'h1);
      wr(upoc_pkg::OFF_DATA, 32'h0);
      wr(upoc_pkg::OFF_CTRL, 32'h302);
      arm();
      look(40, 16'd0, "halfA");
      wr(upoc_pkg::OFF_CTRL, 32'h30A);
      arm();
      look(40, 16'd40, "halfB");
      rd(upoc_pkg::OFF_STATUS, 32'h1, "statusB");
      wr(upoc_pkg::OFF_CTRL, 32'h302);
      wr(upoc_pkg::OFF_CMD, 32'h1);
      arm();
      look(300, 16'd0, "noBurst");
      arm();
      wr(upoc_pkg::OFF_CMD, 32'h2);
      look(40, 16'd1, "single");
      wr(upoc_pkg::OFF_CTRL, 32'h312);
      arm();
      look(2000, 16'd2, "fixedRate");
      wr(upoc_pkg::OFF_CMD, 32'h2);
      rd(upoc_pkg::OFF_CTRL, 32'h302, "errOff");
      arm();
      look(2000, 16'd0, "afterOnce");
      wr(upoc_pkg::OFF_CTRL, 32'h332);
      arm();
      repeat (3)
      begin
         extErrIn <= 1'b1;
         @(posedge mclk);
         extErrIn <= 1'b0;
         repeat (8) @(posedge mclk);
      end
      look(10, 16'd3, "extErr");
      // Aux level picks the half
      wr(upoc_pkg::OFF_CTRL, 32'h300);
      repeat (8) @(posedge mclk);
      auxIn <= 1'b1;
      arm();
      look(30, 16'd30, "auxB");
      auxIn <= 1'b0;
      arm();
      look(30, 16'd0, "auxA");
      // Bursts of half B, internal then external trigger
      wr(upoc_pkg::OFF_CTRL, 32'h306);
      arm();
      wr(upoc_pkg::OFF_CMD, 32'h1);
      look(400, 16'd256, "burstCmd");
      wr(upoc_pkg::OFF_CTRL, 32'h304);
      arm();
      auxIn <= 1'b1;
      repeat (5) @(posedge mclk);
      auxIn <= 1'b0;
      look(400, 16'd256, "burstAux");
      conclude();
   end
endmodule

bind upoc_top upoc_top_checker upoc_top_checker_i (.mclk(mclk), .rstn(rstn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .auxIn(auxIn), .extErrIn(extErrIn),
   .serialOut(serialOut), .halfOut(halfOut), .burstActive(burstActive));
